// *** rtl/psi_panel.sv ***
// Front panel lamps, write-protect tracking and power-fail latch of the tape controller
`timescale 1ns/1ps
`default_nettype none
module psi_panel
    import psi_pkg::*;
#(
    parameter int unsigned SAMPLE_PERIOD = SAMPLE_CYCLES
) (
    input wire logic clk,
    input wire logic rst,
    // Register port
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [DATA_W-1:0] reg_rdata,
    // Controller state
    input wire logic drive_powered,
    input wire logic cmd_active,
    // Panel connector
    input wire logic panel_protect_switch,
    input wire logic power_fail_n,
    output logic ready_lamp_n,
    output logic protect_lamp_n,
    // Tape drive status and control
    input wire logic cartridge_present_n,
    input wire logic cartridge_unsafe_n,
    output logic write_gate_n,
    output logic erase_gate_n,
    output logic drive_inhibit,
    // Interrupt
    output logic irq
);
    // Register decode
    logic sel_ctrl;
    logic sel_status;
    logic sel_irq_stat;
    logic sel_irq_mask;
    logic sel_drive;

    // Full address compare; anything else is unmapped and reads zero
    assign sel_ctrl = (reg_addr == PSI_CTRL_OFS);
    assign sel_status = (reg_addr == PSI_STATUS_OFS);
    assign sel_irq_stat = (reg_addr == PSI_IRQ_STAT_OFS);
    assign sel_irq_mask = (reg_addr == PSI_IRQ_MASK_OFS);
    assign sel_drive = (reg_addr == PSI_DRIVE_OFS);

    logic wr_ctrl;
    logic wr_irq_mask;
    logic wr_drive;
    logic rd_status;
    logic rd_irq_stat;

    // Strobe qualification
    assign wr_ctrl = reg_wr & sel_ctrl;
    assign wr_irq_mask = reg_wr & sel_irq_mask;
    assign wr_drive = reg_wr & sel_drive;
    assign rd_status = reg_rd & sel_status;
    assign rd_irq_stat = reg_rd & sel_irq_stat;

    // Software-written registers
    logic [CTRL_W-1:0] ctrl_q;
    logic [EV_W-1:0] irq_mask_q;
    logic [DRV_W-1:0] drive_q;

    // Plain storage; the drive request bits are gated later, not here
    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl_q <= CTRL_RESET;
            irq_mask_q <= EV_RESET;
            drive_q <= DRV_RESET;
        end else begin
            if (wr_ctrl) begin
                ctrl_q <= reg_wdata[CTRL_W-1:0];
            end
            if (wr_irq_mask) begin
                irq_mask_q <= reg_wdata[EV_W-1:0];
            end
            if (wr_drive) begin
                drive_q <= reg_wdata[DRV_W-1:0];
            end
        end
    end

    // Input conditioning
    logic cart_present;
    logic cart_unsafe;
    logic switch_set;

    // Drive status lines are low-true, the panel switch is high-true
    assign cart_present = ~cartridge_present_n;
    assign cart_unsafe = ~cartridge_unsafe_n;
    assign switch_set = panel_protect_switch;

    // Cartridge load and unload detection
    logic present_q;
    logic load_ev;
    logic unload_ev;

    // Present history starts empty, so a cartridge seated at reset counts as a load
    always_ff @(posedge clk) begin
        if (rst) begin
            present_q <= 1'b0;
        end else begin
            present_q <= cart_present;
        end
    end

    assign load_ev = cart_present & ~present_q;
    assign unload_ev = ~cart_present & present_q;

    // Periodic panel sampling
    logic sample_tick;

    psi_tick #(
        .PERIOD(SAMPLE_PERIOD)
    ) u_sample_tick (
        .clk(clk),
        .rst(rst),
        .tick(sample_tick)
    );

    logic switch_smp_q;
    logic unsafe_smp_q;

    // Panel and plug state only move on the sampling enable; this also
    // rides over switch bounce shorter than the interval
    always_ff @(posedge clk) begin
        if (rst) begin
            switch_smp_q <= 1'b0;
            unsafe_smp_q <= 1'b0;
        end else if (sample_tick) begin
            switch_smp_q <= switch_set;
            unsafe_smp_q <= cart_unsafe;
        end
    end

    // Write-protect state
    logic protect_q;
    logic protect_d;
    logic smp_cond;
    logic load_cond;

    // Blocked when a cartridge is in and either switch or plug says so
    assign smp_cond = cart_present & (switch_set | cart_unsafe);
    assign load_cond = switch_set | cart_unsafe;

    // Unload wins over load, and both win over the periodic check, since a
    // cartridge change must not wait for the next sample
    always_comb begin
        protect_d = protect_q;
        if (unload_ev) begin
            protect_d = 1'b0;
        end else if (load_ev) begin
            protect_d = load_cond;
        end else if (sample_tick && (smp_cond != protect_q)) begin
            protect_d = smp_cond;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            protect_q <= 1'b0;
        end else begin
            protect_q <= protect_d;
        end
    end

    logic protect_ev;

    assign protect_ev = (protect_d != protect_q);

    // Power-fail latch and drive inhibit
    logic pfail_q;
    logic pfail_set;
    logic pfail_seen;
    logic inhibit_q;

    // Any low level on the optional input latches; the input idles high
    assign pfail_set = ~power_fail_n;
    // Controller observes the latch by reading status while it is set
    assign pfail_seen = rd_status & pfail_q;

    psi_sticky #(
        .W(1)
    ) u_pfail_latch (
        .clk(clk),
        .rst(rst),
        .set(pfail_set),
        .clr(rd_status),
        .q(pfail_q)
    );

    // Once seen, drive activity stays stopped until reset: power is going away
    always_ff @(posedge clk) begin
        if (rst) begin
            inhibit_q <= 1'b0;
        end else if (pfail_seen) begin
            inhibit_q <= 1'b1;
        end
    end

    // Lamps and drive gates
    logic ready_d;
    logic write_ok;
    logic erase_ok;
    logic ready_lamp_n_q;
    logic protect_lamp_n_q;
    logic write_gate_n_q;
    logic erase_gate_n_q;

    // Ready needs power, firmware online, no command running and no inhibit
    assign ready_d = drive_powered & ctrl_q[CTRL_ONLINE_BIT] & ~inhibit_q
        & ~cmd_active & ~ctrl_q[CTRL_BUSY_BIT];
    // Gates use the next protect value so they drop in the same edge as the lamp
    assign write_ok = drive_q[DRV_WRITE_BIT] & ~protect_d & ~inhibit_q;
    assign erase_ok = drive_q[DRV_ERASE_BIT] & ~protect_d & ~inhibit_q;

    // All pin outputs from flops; lamps and gates are low-true
    always_ff @(posedge clk) begin
        if (rst) begin
            ready_lamp_n_q <= 1'b1;
            protect_lamp_n_q <= 1'b1;
            write_gate_n_q <= 1'b1;
            erase_gate_n_q <= 1'b1;
        end else begin
            ready_lamp_n_q <= ~ready_d;
            protect_lamp_n_q <= ~protect_d;
            write_gate_n_q <= ~write_ok;
            erase_gate_n_q <= ~erase_ok;
        end
    end

    assign ready_lamp_n = ready_lamp_n_q;
    assign protect_lamp_n = protect_lamp_n_q;
    assign write_gate_n = write_gate_n_q;
    assign erase_gate_n = erase_gate_n_q;
    assign drive_inhibit = inhibit_q;

    // Interrupt status and output
    logic [EV_W-1:0] ev_set;
    logic [EV_W-1:0] ev_clr;
    logic [EV_W-1:0] irq_stat_q;
    logic irq_q;

    // Power fail reports its rising latch, the rest are single-cycle events
    assign ev_set = {unload_ev, load_ev, protect_ev, pfail_set & ~pfail_q};
    // A read of the interrupt status clears every bit it returned
    assign ev_clr = {EV_W{rd_irq_stat}};

    psi_sticky #(
        .W(EV_W)
    ) u_irq_stat (
        .clk(clk),
        .rst(rst),
        .set(ev_set),
        .clr(ev_clr),
        .q(irq_stat_q)
    );

    // Level interrupt from a flop, one cycle behind the status bits
    always_ff @(posedge clk) begin
        if (rst) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(irq_stat_q & irq_mask_q);
        end
    end

    assign irq = irq_q;

    // Read data
    logic [ST_W-1:0] status_word;
    logic [DATA_W-1:0] rd_mux;
    logic [DATA_W-1:0] rdata_q;

    // Live status; bits above the field widths read as zero
    assign status_word = {~ready_lamp_n_q, inhibit_q, pfail_q, switch_smp_q,
        unsafe_smp_q, cart_present, protect_q};

    assign rd_mux = sel_ctrl ? {{(DATA_W-CTRL_W){1'b0}}, ctrl_q}
        : sel_status ? {{(DATA_W-ST_W){1'b0}}, status_word}
        : sel_irq_stat ? {{(DATA_W-EV_W){1'b0}}, irq_stat_q}
        : sel_irq_mask ? {{(DATA_W-EV_W){1'b0}}, irq_mask_q}
        : sel_drive ? {{(DATA_W-DRV_W){1'b0}}, drive_q}
        : {DATA_W{1'b0}};

    // Data stands only in the cycle after the read strobe
    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_q <= {DATA_W{1'b0}};
        end else if (reg_rd) begin
            rdata_q <= rd_mux;
        end else begin
            rdata_q <= {DATA_W{1'b0}};
        end
    end

    assign reg_rdata = rdata_q;
endmodule : psi_panel
`default_nettype wire

// *** rtl/psi_pkg.sv ***
// Package of offsets, fields, reset values and timing for the panel status indicators
// Summary of operation
// - Ready lamp lit while drive powered and controller able to take commands.
// - Ready lamp dark while a received host command is being carried out.
// - Protect lamp lit when a cartridge is in and panel protect switch set or cartridge reports unsafe.
// - Panel switches sampled at a regular interval; lamp refreshed when condition changes.
// - On cartridge load, safe-plug status is read and protect lamp updated.
// - Protect lamp off on cartridge unload or when the protect switch clears with the plug safe.
// - Low power-fail input sets a sticky latch held until the controller reads it.
// - Once the controller has seen the power-fail latch, all drive activity stops.
// - Lamp outputs are active low; panel protect switch reads active high.
package psi_pkg;
    // Register bus shape
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // Register byte offsets
    localparam logic [7:0] PSI_CTRL_OFS = 8'h00;
    localparam logic [7:0] PSI_STATUS_OFS = 8'h04;
    localparam logic [7:0] PSI_IRQ_STAT_OFS = 8'h08;
    localparam logic [7:0] PSI_IRQ_MASK_OFS = 8'h0c;
    localparam logic [7:0] PSI_DRIVE_OFS = 8'h10;

    // Control register fields
    localparam int CTRL_ONLINE_BIT = 0;
    localparam int CTRL_BUSY_BIT = 1;
    localparam int CTRL_W = 2;
    localparam logic [1:0] CTRL_RESET = 2'h0;

    // Drive control register fields
    localparam int DRV_WRITE_BIT = 0;
    localparam int DRV_ERASE_BIT = 1;
    localparam int DRV_W = 2;
    localparam logic [1:0] DRV_RESET = 2'h0;

    // Status register fields
    localparam int ST_PROTECT_BIT = 0;
    localparam int ST_PRESENT_BIT = 1;
    localparam int ST_UNSAFE_BIT = 2;
    localparam int ST_SWITCH_BIT = 3;
    localparam int ST_PFAIL_BIT = 4;
    localparam int ST_INHIBIT_BIT = 5;
    localparam int ST_READY_BIT = 6;
    localparam int ST_W = 7;

    // Interrupt event fields, shared by status and mask
    localparam int EV_PFAIL_BIT = 0;
    localparam int EV_PROTECT_BIT = 1;
    localparam int EV_LOAD_BIT = 2;
    localparam int EV_UNLOAD_BIT = 3;
    localparam int EV_W = 4;
    localparam logic [3:0] EV_RESET = 4'h0;

    // Switch sampling interval
    localparam int CLK_MHZ = 200;
    localparam int SAMPLE_US = 1000;
    localparam int SAMPLE_CYCLES = SAMPLE_US * CLK_MHZ;
endpackage : psi_pkg

// *** rtl/psi_sticky.sv ***
// Bank of sticky flags where a set in the clearing cycle wins over the clear
`timescale 1ns/1ps
`default_nettype none
module psi_sticky #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [W-1:0] set,
    input wire logic [W-1:0] clr,
    output logic [W-1:0] q
);
    logic [W-1:0] q_d;

    // Set is ORed after the clear so a coincident event is never lost
    assign q_d = (q & ~clr) | set;

    always_ff @(posedge clk) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= q_d;
        end
    end
endmodule : psi_sticky
`default_nettype wire

// *** rtl/psi_tick.sv ***
// Free-running divider that yields a one-cycle enable pulse every PERIOD cycles
`timescale 1ns/1ps
`default_nettype none
module psi_tick #(
    parameter int unsigned PERIOD = 4
) (
    input wire logic clk,
    input wire logic rst,
    output logic tick
);
    logic [31:0] cnt_q;
    logic [31:0] cnt_d;
    logic wrap;

    // Count down so the compare is against a constant zero
    assign wrap = (cnt_q == 32'h0);
    assign cnt_d = wrap ? 32'(PERIOD - 1) : cnt_q - 32'h1;
    assign tick = wrap;

    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_q <= 32'h0;
        end else begin
            cnt_q <= cnt_d;
        end
    end
endmodule : psi_tick
`default_nettype wire

// *** tb/psi_far_side.sv ***
// Model of the panel switches and the tape drive status lines
`timescale 1ns/1ps
`default_nettype none
module psi_far_side (
    input wire logic cart_in,
    input wire logic plug_unsafe,
    input wire logic sw_set,
    input wire logic pf,
    output logic cartridge_present_n,
    output logic cartridge_unsafe_n,
    output logic panel_protect_switch,
    output logic power_fail_n
);
    // Plug line only means something with a cartridge in; the pull-up wins otherwise
    assign cartridge_unsafe_n = !(cart_in && plug_unsafe);
    assign cartridge_present_n = !cart_in;
    assign panel_protect_switch = sw_set;
    assign power_fail_n = !pf;
endmodule : psi_far_side
`default_nettype wire

// *** tb/psi_panel_properties.sv ***
// Port-level assertions for the panel status indicators
`timescale 1ns/1ps
`default_nettype none
module psi_panel_checker
    import psi_pkg::*;
#(
    parameter int unsigned SAMPLE_PERIOD = SAMPLE_CYCLES
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [DATA_W-1:0] reg_rdata,
    input wire logic drive_powered,
    input wire logic cmd_active,
    input wire logic panel_protect_switch,
    input wire logic power_fail_n,
    input wire logic ready_lamp_n,
    input wire logic protect_lamp_n,
    input wire logic cartridge_present_n,
    input wire logic cartridge_unsafe_n,
    input wire logic write_gate_n,
    input wire logic erase_gate_n,
    input wire logic drive_inhibit,
    input wire logic irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // Status read decode, the only thing that clears the power-fail latch
    wire logic st_rd = reg_rd && (reg_addr == PSI_STATUS_OFS);

    property p_cmd_dark; cmd_active |=> ready_lamp_n; endproperty
    a_cmd_dark: assert property (p_cmd_dark) else $error("ready lit in command");
    property p_unpowered; !drive_powered |=> ready_lamp_n; endproperty
    a_unpowered: assert property (p_unpowered) else $error("ready lit unpowered");
    property p_inh_dark; drive_inhibit |=> ready_lamp_n && write_gate_n && erase_gate_n; endproperty
    a_inh_dark: assert property (p_inh_dark) else $error("activity while inhibited");
    property p_gate_prot; !protect_lamp_n |-> write_gate_n && erase_gate_n; endproperty
    a_gate_prot: assert property (p_gate_prot) else $error("gate open while protected");
    property p_unload; $rose(cartridge_present_n) |=> protect_lamp_n; endproperty
    a_unload: assert property (p_unload) else $error("protect lamp on after unload");
    // Load takes the plug and switch state seen on the load edge
    property p_load;
        $fell(cartridge_present_n) |=>
            protect_lamp_n == !($past(panel_protect_switch) || !$past(cartridge_unsafe_n));
    endproperty
    a_load: assert property (p_load) else $error("protect lamp wrong after load");
    property p_absent; cartridge_present_n [*2] |-> protect_lamp_n; endproperty
    a_absent: assert property (p_absent) else $error("protect lamp on with no cartridge");
    property p_pf_latch; !power_fail_n ##1 st_rd |=> reg_rdata[ST_PFAIL_BIT]; endproperty
    a_pf_latch: assert property (p_pf_latch) else $error("power fail not latched");
    property p_pf_inh; st_rd ##1 reg_rdata[ST_PFAIL_BIT] |-> drive_inhibit; endproperty
    a_pf_inh: assert property (p_pf_inh) else $error("no inhibit after power fail");
    property p_inh_hold; drive_inhibit |=> drive_inhibit; endproperty
    a_inh_hold: assert property (p_inh_hold) else $error("inhibit dropped");

    c_load: cover property ($fell(cartridge_present_n));
    c_unload: cover property ($rose(cartridge_present_n));
    c_inhibit: cover property ($rose(drive_inhibit));
endmodule : psi_panel_checker

bind psi_panel psi_panel_checker #(.SAMPLE_PERIOD(SAMPLE_PERIOD)) u_chk (
    .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .drive_powered(drive_powered),
    .cmd_active(cmd_active), .panel_protect_switch(panel_protect_switch),
    .power_fail_n(power_fail_n), .ready_lamp_n(ready_lamp_n),
    .protect_lamp_n(protect_lamp_n), .cartridge_present_n(cartridge_present_n),
    .cartridge_unsafe_n(cartridge_unsafe_n), .write_gate_n(write_gate_n),
    .erase_gate_n(erase_gate_n), .drive_inhibit(drive_inhibit), .irq(irq)
);
`default_nettype wire

// *** tb/tb_panel_status_indicators.sv ***
// Self-checking testbench for the panel status indicators
`timescale 1ns/1ps
`default_nettype none
module tb_panel_status_indicators
    import psi_pkg::*;
;
    localparam int SP = 8;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [ADDR_W-1:0] reg_addr = '0;
    logic [DATA_W-1:0] reg_wdata = '0;
    logic [DATA_W-1:0] reg_rdata;
    logic reg_wr = 1'b0, reg_rd = 1'b0, drive_powered = 1'b0, cmd_active = 1'b0;
    logic cart_in = 1'b0, plug_unsafe = 1'b0, sw_set = 1'b0, pf = 1'b0;
    wire logic present_n, unsafe_n, sw, pf_n;
    logic ready_lamp_n, protect_lamp_n, write_gate_n, erase_gate_n, drive_inhibit, irq;
    int bad_count = 0;
    int n_tests = 0;

    // 200 MHz clock
    always #2.5 clk = ~clk;

    psi_panel #(.SAMPLE_PERIOD(SP)) DUT (
        .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .drive_powered(drive_powered),
        .cmd_active(cmd_active), .panel_protect_switch(sw), .power_fail_n(pf_n),
        .ready_lamp_n(ready_lamp_n), .protect_lamp_n(protect_lamp_n),
        .cartridge_present_n(present_n), .cartridge_unsafe_n(unsafe_n),
        .write_gate_n(write_gate_n), .erase_gate_n(erase_gate_n),
        .drive_inhibit(drive_inhibit), .irq(irq)
    );
    psi_far_side u_far (
        .cart_in(cart_in), .plug_unsafe(plug_unsafe), .sw_set(sw_set), .pf(pf),
        .cartridge_present_n(present_n), .cartridge_unsafe_n(unsafe_n),
        .panel_protect_switch(sw), .power_fail_n(pf_n)
    );

    task automatic end_of_test();
        if (bad_count == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : end_of_test

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h got %h", nm, exp, got);
        end
    endtask : chk

    // Wait whole cycles, then step past the edge so outputs have settled
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 q = reg_rdata;
    endtask : rd

    task automatic crd(input string nm, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        rd(a, q);
        chk(nm, exp, q);
    endtask : crd

    task automatic t_regs();
        crd("ctrl", PSI_CTRL_OFS, 32'h0);
        crd("mask", PSI_IRQ_MASK_OFS, 32'h0);
        crd("drive", PSI_DRIVE_OFS, 32'h0);
        wr(8'h14, 32'hffffffff);
        crd("unmapped", 8'h14, 32'h0);
        wr(PSI_IRQ_MASK_OFS, 32'hffffffff);
        crd("mask width", PSI_IRQ_MASK_OFS, 32'hf);
        wr(PSI_IRQ_MASK_OFS, 32'h5);
    endtask : t_regs

    task automatic t_ready();
        @(posedge clk);
        drive_powered <= 1'b1;
        wr(PSI_CTRL_OFS, 32'h1);
        cyc(3);
        chk("ready idle", 0, ready_lamp_n);
        @(posedge clk);
        cmd_active <= 1'b1;
        cyc(3);
        chk("ready cmd", 1, ready_lamp_n);
        @(posedge clk);
        cmd_active <= 1'b0;
        wr(PSI_CTRL_OFS, 32'h3);
        cyc(3);
        chk("ready busy", 1, ready_lamp_n);
        wr(PSI_CTRL_OFS, 32'h1);
        @(posedge clk);
        drive_powered <= 1'b0;
        cyc(3);
        chk("ready off", 1, ready_lamp_n);
        @(posedge clk);
        drive_powered <= 1'b1;
    endtask : t_ready

    task automatic t_protect();
        logic [31:0] q;
        wr(PSI_DRIVE_OFS, 32'h3);
        rd(PSI_IRQ_STAT_OFS, q);
        @(posedge clk);
        cart_in <= 1'b1;
        plug_unsafe <= 1'b1;
        cyc(3);
        chk("load unsafe", 0, protect_lamp_n);
        chk("write gate", 1, write_gate_n);
        chk("erase gate", 1, erase_gate_n);
        crd("events", PSI_IRQ_STAT_OFS, 32'h6);
        @(posedge clk);
        plug_unsafe <= 1'b0;
        cyc(2 * SP);
        chk("plug safe", 1, protect_lamp_n);
        chk("write open", 0, write_gate_n);
        chk("erase open", 0, erase_gate_n);
        @(posedge clk);
        sw_set <= 1'b1;
        cyc(2 * SP);
        chk("switch set", 0, protect_lamp_n);
        // Protect, present, sampled switch and ready lamp on; plug sampled safe
        crd("status", PSI_STATUS_OFS, 32'h0000004b);
        @(posedge clk);
        cart_in <= 1'b0;
        cyc(2);
        chk("unload", 1, protect_lamp_n);
        crd("events", PSI_IRQ_STAT_OFS, 32'ha);
        @(posedge clk);
        cart_in <= 1'b1;
        cyc(2);
        chk("load switch", 0, protect_lamp_n);
        @(posedge clk);
        sw_set <= 1'b0;
        cyc(2 * SP);
        chk("switch reset", 1, protect_lamp_n);
    endtask : t_protect

    // A power-fail pulse must lock out the drive once the status is read
    task automatic t_pfail();
        logic [31:0] q;
        rd(PSI_IRQ_STAT_OFS, q);
        cyc(2);
        chk("irq quiet", 0, irq);
        @(posedge clk);
        pf <= 1'b1;
        @(posedge clk);
        pf <= 1'b0;
        cyc(3);
        chk("irq pfail", 1, irq);
        rd(PSI_STATUS_OFS, q);
        chk("pfail latch", 1, q[ST_PFAIL_BIT]);
        cyc(2);
        chk("inhibit", 1, drive_inhibit);
        chk("ready inh", 1, ready_lamp_n);
        chk("write inh", 1, write_gate_n);
        rd(PSI_STATUS_OFS, q);
        chk("pfail clear", 0, q[ST_PFAIL_BIT]);
        // Status read right behind a low input: the latch must already show it
        @(posedge clk);
        pf <= 1'b1;
        rd(PSI_STATUS_OFS, q);
        chk("pfail live", 1, q[ST_PFAIL_BIT]);
        @(posedge clk);
        pf <= 1'b0;
        rd(PSI_STATUS_OFS, q);
        chk("pfail held", 1, q[ST_PFAIL_BIT]);
        rd(PSI_STATUS_OFS, q);
        chk("pfail cleared", 0, q[ST_PFAIL_BIT]);
    endtask : t_pfail

    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_ready();
        t_protect();
        t_pfail();
        end_of_test();
    end

    // Whole run is under two hundred cycles; this limit only cuts a hang
    initial begin
        #20000;
        bad_count++;
        end_of_test();
    end
endmodule : tb_panel_status_indicators
`default_nettype wire
